// ### core/input_capture_channels.sv
// Purpose: Four input capture channels with prescaler, FIFO, flags and wake-up.
// Assumes: Timebase counts and CPU power state come from logic on the same clock.
// Notes:   Registers are reached over a plain strobe port; read data follow by one cycle.
`timescale 1ns/1ns

module input_capture_channels #(
  parameter int NCH = capture_pkg::NUM_CH
) (
  input  wire logic                                clock,
  input  wire logic                                nrst,
  input  wire capture_pkg::regReq_s                regReq,
  output logic      [capture_pkg::DATA_W-1:0]      regRdata,
  input  wire logic [NCH-1:0]                      capturePin,
  input  wire logic [capture_pkg::DATA_W-1:0]      timebaseA,
  input  wire logic [capture_pkg::DATA_W-1:0]      timebaseB,
  input  wire logic                                cpuIdle,
  input  wire logic                                cpuSleep,
  output logic      [NCH-1:0]                      irqFlag,
  output logic                                     wakeReq
);

  import capture_pkg::*;

  // ***************************************************************
  // Declarations
  // ***************************************************************
  ctrl_s             ctrl_r      [NCH];
  logic [3:0]        presc_r     [NCH];
  logic [1:0]        irqCnt_r    [NCH];
  logic [NCH-1:0]    ovf_r;
  logic [NCH-1:0]    ovLock_r;
  logic [NCH-1:0]    flag_r;
  logic [NCH-1:0]    irqEn_r;
  logic [DATA_W-1:0] rdata_r;
  logic              wake_r;

  logic [NCH-1:0]    rise;
  logic [NCH-1:0]    fall;
  logic [NCH-1:0]    halted;
  logic [NCH-1:0]    prescHit;
  logic [NCH-1:0]    capEvent;
  logic [NCH-1:0]    push;
  logic [NCH-1:0]    overflowHit;
  logic [NCH-1:0]    flagSet;
  logic [NCH-1:0]    conWr;
  logic [NCH-1:0]    bufRd;
  logic [NCH-1:0]    fifoEmpty;
  logic [NCH-1:0]    fifoFull;
  logic [DATA_W-1:0] fifoHead    [NCH];
  logic [DATA_W-1:0] stamp       [NCH];
  logic [DATA_W-1:0] rdataNxt;

  // ***************************************************************
  // Per-channel pin front end and buffer
  // ***************************************************************
  for (genvar g = 0; g < NCH; g++) begin : gChan
    pin_edge_detect uEdge (
      .clock (clock),
      .nrst  (nrst),
      .pin   (capturePin[g]),
      .rise  (rise[g]),
      .fall  (fall[g])
    );

    capture_fifo #(
      .WIDTH (DATA_W),
      .DEPTH (FIFO_DEPTH)
    ) uFifo (
      .clock    (clock),
      .nrst     (nrst),
      .push     (push[g]),
      .pushData (stamp[g]),
      .pop      (bufRd[g]),
      .head     (fifoHead[g]),
      .empty    (fifoEmpty[g]),
      .full     (fifoFull[g])
    );
  end

  // ***************************************************************
  // Address decode
  // ***************************************************************
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      conWr[i] = regReq.wr && (regReq.addr == CON_OFS[i]);
      // A read of an empty buffer leaves the FIFO untouched; its data are undefined.
      bufRd[i] = regReq.rd && (regReq.addr == BUF_OFS[i]); // see RL7 see RL10
    end
  end

  // ***************************************************************
  // Event qualification
  // ***************************************************************
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      // Sleep stops the capture path; Idle stops it only when idle-halt is set.
      halted[i] = cpuSleep || (cpuIdle && ctrl_r[i].idleHalt); // see RL20 see RL17
      // Bit 7 set picks timebase A; reset value selects timebase B.
      stamp[i] = ctrl_r[i].tbSel ? timebaseA : timebaseB; // see RL11 see RL21
      unique case (ctrl_r[i].mode)
        MODE_RISE4:  prescHit[i] = rise[i] && (presc_r[i] == PRESC4_LAST);
        MODE_RISE16: prescHit[i] = rise[i] && (presc_r[i] == PRESC16_LAST);
        default:     prescHit[i] = 1'b0;
      endcase
      unique case (ctrl_r[i].mode)
        MODE_BOTH:   capEvent[i] = rise[i] || fall[i]; // see RL2
        MODE_FALL:   capEvent[i] = fall[i]; // see RL2
        MODE_RISE:   capEvent[i] = rise[i]; // see RL2
        MODE_RISE4,
        MODE_RISE16: capEvent[i] = prescHit[i]; // see RL2
        default:     capEvent[i] = 1'b0;
      endcase
      capEvent[i] = capEvent[i] && !halted[i];
      // Full buffer: the new stamp is dropped; every-edge mode drops it silently.
      push[i] = capEvent[i] && !fifoFull[i] && !ovLock_r[i]; // see RL5 see RL21 see RL9
      overflowHit[i] = capEvent[i] && fifoFull[i] && !ovLock_r[i]
                       && (ctrl_r[i].mode != MODE_BOTH); // see RL8 see RL14
    end
  end

  // ***************************************************************
  // Control registers
  // ***************************************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NCH; i++) ctrl_r[i] <= CTRL_RESET;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (conWr[i]) begin
          ctrl_r[i].idleHalt <= regReq.wdata[IDLE_HALT_BIT];
          ctrl_r[i].tbSel    <= regReq.wdata[TB_SEL_BIT];
          ctrl_r[i].perIrq   <= regReq.wdata[PER_IRQ_LSB +: 2];
          ctrl_r[i].mode     <= regReq.wdata[MODE_LSB +: 3];
        end
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irqEn_r <= '0;
    end else if (regReq.wr && (regReq.addr == IRQ_EN_OFS)) begin
      irqEn_r <= regReq.wdata[NCH-1:0];
    end
  end

  // ***************************************************************
  // Capture prescaler
  // ***************************************************************
  // The prescaler only counts in the 4:1 and 16:1 modes and holds while halted,
  // so 4:1 and 16:1 cannot run in Sleep.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NCH; i++) presc_r[i] <= 4'h0; // see RL4
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (ctrl_r[i].mode == MODE_OFF) begin
          presc_r[i] <= 4'h0; // see RL3
        end else if (prescHit[i] && !halted[i]) begin
          presc_r[i] <= 4'h0;
        end else if (rise[i] && !halted[i] &&
                     ((ctrl_r[i].mode == MODE_RISE4) || (ctrl_r[i].mode == MODE_RISE16))) begin
          presc_r[i] <= presc_r[i] + 4'h1; // see RL18 see RL20
        end
      end
    end
  end

  // ***************************************************************
  // Overflow flag and lock
  // ***************************************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ovf_r    <= '0;
      ovLock_r <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        // Set wins over a clearing write in the same cycle.
        if (overflowHit[i]) begin
          ovf_r[i] <= 1'b1; // see RL8
        end else if (conWr[i] && !regReq.wdata[OVF_BIT]) begin
          ovf_r[i] <= 1'b0;
        end
        if (overflowHit[i]) begin
          ovLock_r[i] <= 1'b1; // see RL9
        end else if (fifoEmpty[i]) begin
          ovLock_r[i] <= 1'b0; // see RL9
        end
      end
    end
  end

  // ***************************************************************
  // Interrupt counting and flags
  // ***************************************************************
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      if (ctrl_r[i].mode == MODE_WAKE) begin
        // Interrupt-only mode works in Sleep and Idle regardless of timebase state.
        flagSet[i] = rise[i]; // see RL16 see RL17 see RL15
      end else if (ctrl_r[i].mode == MODE_BOTH) begin
        flagSet[i] = capEvent[i]; // see RL12 see RL13
      end else begin
        flagSet[i] = capEvent[i] && (irqCnt_r[i] == ctrl_r[i].perIrq); // see RL19
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NCH; i++) irqCnt_r[i] <= 2'h0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if ((ctrl_r[i].mode == MODE_OFF) || (ctrl_r[i].mode == MODE_BOTH)) begin
          irqCnt_r[i] <= 2'h0; // see RL13
        end else if (capEvent[i]) begin
          irqCnt_r[i] <= (irqCnt_r[i] == ctrl_r[i].perIrq) ? 2'h0 : irqCnt_r[i] + 2'h1; // see RL19
        end
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      flag_r <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        // Hardware set beats a software clear in the same cycle.
        if (flagSet[i]) begin
          flag_r[i] <= 1'b1; // see RL1
        end else if (regReq.wr && (regReq.addr == IRQ_FLAG_OFS)) begin
          flag_r[i] <= regReq.wdata[i];
        end
      end
    end
  end

  // ***************************************************************
  // Wake-up request
  // ***************************************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wake_r <= 1'b0;
    end else begin
      wake_r <= (cpuIdle || cpuSleep) && |(flag_r & irqEn_r); // see RL15 see RL16
    end
  end

  // ***************************************************************
  // Read data
  // ***************************************************************
  always_comb begin
    rdataNxt = '0;
    for (int i = 0; i < NCH; i++) begin
      if (regReq.addr == BUF_OFS[i]) begin
        rdataNxt = fifoHead[i]; // see RL7
      end
      if (regReq.addr == CON_OFS[i]) begin
        rdataNxt[IDLE_HALT_BIT]     = ctrl_r[i].idleHalt;
        rdataNxt[TB_SEL_BIT]        = ctrl_r[i].tbSel;
        rdataNxt[PER_IRQ_LSB +: 2]  = ctrl_r[i].perIrq;
        rdataNxt[OVF_BIT]           = ovf_r[i];
        rdataNxt[BNE_BIT]           = !fifoEmpty[i]; // see RL6
        rdataNxt[MODE_LSB +: 3]     = ctrl_r[i].mode;
      end
    end
    if (regReq.addr == IRQ_FLAG_OFS) begin
      rdataNxt[NCH-1:0] = flag_r;
    end
    if (regReq.addr == IRQ_EN_OFS) begin
      rdataNxt[NCH-1:0] = irqEn_r;
    end
  end

  // Data stand only in the cycle after the read strobe; otherwise the port reads zero.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= regReq.rd ? rdataNxt : '0;
    end
  end

  assign regRdata = rdata_r;
  assign irqFlag  = flag_r;
  assign wakeReq  = wake_r;

endmodule : input_capture_channels

// ### core/capture_pkg.sv
// Purpose: Shared constants and types for the four-channel input capture block.
// Assumes: 16-bit register port with byte addresses; one clock domain.
// Notes:   Channel index 0..3 stands for channels 1, 2, 7 and 8.
//
// Overview of operation
// RL1 - Four independent capture channels, each with control, buffer, flag and enable.
// RL2 - Three-bit mode picks falling, rising, 4th rising, 16th rising or both edges.
// RL3 - Turning a channel off through its mode field clears its prescaler.
// RL4 - Any reset clears every channel prescaler.
// RL5 - Each channel buffers timestamps in a four-entry, 16-bit FIFO.
// RL6 - Not-empty flag sets on first capture, stays until all entries are read.
// RL7 - Each buffer read returns the oldest entry and advances the rest.
// RL8 - Fifth capture into a full buffer sets overflow and is dropped.
// RL9 - After overflow, captures are ignored until all four entries are read.
// RL10 - Software must not read an empty buffer; such data is undefined.
// RL11 - Control bit 7 selects the timebase; timebase B is the default.
// RL12 - In every-edge mode the interrupt flag sets on each captured edge.
// RL13 - In every-edge mode the events-per-interrupt field is ignored.
// RL14 - In every-edge mode no overflow is ever raised.
// RL15 - Enabled capture events in Idle or Sleep give a wake-up or interrupt.
// RL16 - Mode 111 with enable set wakes the CPU whether or not timebase runs.
// RL17 - In Sleep the events-per-interrupt field has no effect; only interrupt source.
// RL18 - Software must use mode 111 in Sleep; 4:1 and 16:1 prescales stop.
// RL19 - Control bits 6:5 choose how many events set the interrupt flag.
// RL20 - In Idle with idle-halt clear, full capture and prescaling keep working.
// RL21 - Each qualifying event writes the selected timebase count into the buffer tail.

package capture_pkg;

  localparam int NUM_CH     = 4;
  localparam int DATA_W     = 16;
  localparam int ADDR_W     = 16;
  localparam int FIFO_DEPTH = 4;

  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam logic [ADDR_W-1:0] BUF_OFS [NUM_CH] = '{16'h0140, 16'h0144, 16'h0158, 16'h015C};
  localparam logic [ADDR_W-1:0] CON_OFS [NUM_CH] = '{16'h0142, 16'h0146, 16'h015A, 16'h015E};
  localparam logic [ADDR_W-1:0] IRQ_FLAG_OFS = 16'h0160;
  localparam logic [ADDR_W-1:0] IRQ_EN_OFS   = 16'h0162;

  // ***************************************************************
  // Control register fields
  // ***************************************************************
  localparam int IDLE_HALT_BIT = 13;
  localparam int TB_SEL_BIT    = 7;
  localparam int PER_IRQ_LSB   = 5;
  localparam int OVF_BIT       = 4;
  localparam int BNE_BIT       = 3;
  localparam int MODE_LSB      = 0;

  localparam logic [2:0] MODE_OFF    = 3'h0;
  localparam logic [2:0] MODE_BOTH   = 3'h1;
  localparam logic [2:0] MODE_FALL   = 3'h2;
  localparam logic [2:0] MODE_RISE   = 3'h3;
  localparam logic [2:0] MODE_RISE4  = 3'h4;
  localparam logic [2:0] MODE_RISE16 = 3'h5;
  localparam logic [2:0] MODE_WAKE   = 3'h7;

  localparam logic [3:0] PRESC4_LAST  = 4'h3;
  localparam logic [3:0] PRESC16_LAST = 4'hF;

  typedef struct packed {
    logic       idleHalt;
    logic       tbSel;
    logic [1:0] perIrq;
    logic [2:0] mode;
  } ctrl_s;

  localparam ctrl_s CTRL_RESET = '{idleHalt: 1'b0, tbSel: 1'b0, perIrq: 2'h0, mode: 3'h0};

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } regReq_s;

endpackage : capture_pkg

// ### core/pin_edge_detect.sv
// Purpose: Bring one capture pin into the clock domain and flag its edges.
// Assumes: Pin is asynchronous to clock.
// Notes:   Edge pulses appear two edges after the pin changes.
`timescale 1ns/1ns

module pin_edge_detect (
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic pin,
  output logic      rise,
  output logic      fall
);

  logic meta_r;
  logic sync_r;
  logic last_r;

  // The first stage is read by the second stage only, to keep metastability out of logic.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      meta_r <= pin;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign rise = sync_r & ~last_r;
  assign fall = ~sync_r & last_r;

endmodule : pin_edge_detect

// ### core/capture_fifo.sv
// Purpose: Shift-style FIFO holding captured timestamps, oldest at the head.
// Assumes: Caller never pushes when full; pop when empty is ignored.
// Notes:   A pop shifts every remaining entry one place toward the head.
`timescale 1ns/1ns

module capture_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] pushData,
  input  wire logic             pop,
  output logic      [WIDTH-1:0] head,
  output logic                  empty,
  output logic                  full
);

  logic [WIDTH-1:0]         slot_r [DEPTH];
  logic [$clog2(DEPTH+1)-1:0] count_r;
  logic                     doPop;
  logic [$clog2(DEPTH+1)-1:0] tail;

  assign doPop = pop & (count_r != '0);
  assign tail  = doPop ? count_r - 1'b1 : count_r;
  assign empty = (count_r == '0);
  assign full  = (count_r == DEPTH[$clog2(DEPTH+1)-1:0]);
  assign head  = slot_r[0];

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      count_r <= '0;
    end else begin
      count_r <= tail + (push ? 1'b1 : 1'b0);
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int k = 0; k < DEPTH; k++) slot_r[k] <= '0;
    end else begin
      for (int k = 0; k < DEPTH; k++) begin
        if (push && (tail == k[$clog2(DEPTH+1)-1:0])) begin
          slot_r[k] <= pushData;
        end else if (doPop && (k < DEPTH - 1)) begin
          slot_r[k] <= slot_r[k+1];
        end
      end
    end
  end

endmodule : capture_fifo

// ### tb/capture_props.sv
// Purpose: Port-level checks for the input capture block.
// Assumes: One clock; read data stand only in the cycle after the read strobe.
// Notes:   Channel enables are internal, so the wake checks only bound it from above.
`timescale 1ns/1ns

module capture_props #(
  parameter int NCH = capture_pkg::NUM_CH
) (
  input wire logic                           clock,
  input wire logic                           nrst,
  input wire capture_pkg::regReq_s           regReq,
  input wire logic [capture_pkg::DATA_W-1:0] regRdata,
  input wire logic [NCH-1:0]                 capturePin,
  input wire logic [capture_pkg::DATA_W-1:0] timebaseA,
  input wire logic [capture_pkg::DATA_W-1:0] timebaseB,
  input wire logic                           cpuIdle,
  input wire logic                           cpuSleep,
  input wire logic [NCH-1:0]                 irqFlag,
  input wire logic                           wakeReq
);
  import capture_pkg::*;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  logic flagWr;
  logic mapped;

  assign flagWr = regReq.wr && regReq.addr == IRQ_FLAG_OFS;

  always_comb begin
    mapped = regReq.addr == IRQ_FLAG_OFS || regReq.addr == IRQ_EN_OFS;
    for (int i = 0; i < NUM_CH; i++) begin
      if (regReq.addr == BUF_OFS[i] || regReq.addr == CON_OFS[i]) begin
        mapped = 1'b1;
      end
    end
  end

  // A flag may only rise from a pin change within the last six cycles, wider than the synchroniser delay, or a write.
  sequence quietPins;
    $stable(capturePin) && !flagWr;
  endsequence

  a_rdata_idle_zero: assert property (!regReq.rd |=> regRdata == '0)
    else $error("read data not zero outside a read");
  a_unmapped_zero: assert property (regReq.rd && !mapped |=> regRdata == '0)
    else $error("unmapped read returned data");
  a_flag_read_back: assert property (regReq.rd && regReq.addr == IRQ_FLAG_OFS
    |=> regRdata == DATA_W'($past(irqFlag))) else $error("flag register read mismatch");
  a_flag_write_sets: assert property (flagWr
    |=> (irqFlag & $past(regReq.wdata[NCH-1:0])) == $past(regReq.wdata[NCH-1:0]))
    else $error("flag write did not set flags");
  a_flag_sticky: assert property (!flagWr
    |=> (irqFlag & $past(irqFlag)) == $past(irqFlag)) else $error("flag fell without write");
  a_flag_needs_edge: assert property (quietPins [*6]
    |-> (irqFlag & ~$past(irqFlag)) == '0) else $error("flag rose without pin edge");
  a_wake_needs_flag: assert property (irqFlag == '0 |=> !wakeReq)
    else $error("wake without any flag");
  a_wake_needs_state: assert property (!(cpuIdle || cpuSleep) |=> !wakeReq)
    else $error("wake while running");
endmodule : capture_props

// ### tb/pin_source.sv
// Purpose: Signal source on the capture pins, answering promptly or late.
// Assumes: The bench holds each level long enough for the pipeline to settle.
// Notes:   Lag is only changed while all stages agree, so no glitch is made.
`timescale 1ns/1ns

module pin_source #(
  parameter int NCH = 4
) (
  input  wire logic           clock,
  input  wire logic           nrst,
  input  wire logic [NCH-1:0] level,
  input  wire logic [1:0]     lag,
  output logic      [NCH-1:0] pin
);
  logic [NCH-1:0] stage_r [3];

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stage_r <= '{default: '0};
    end else begin
      stage_r[0] <= level;
      stage_r[1] <= stage_r[0];
      stage_r[2] <= stage_r[1];
    end
  end

  assign pin = stage_r[lag];
endmodule : pin_source

// ### tb/input_capture_channels_bench.sv
// Purpose: Self-checking bench for the four-channel input capture block.
// Assumes: Timebases are held still around each pin edge so stamps are exact.
// Notes:   A bench-side model predicts buffer contents, status bits and flags.
`timescale 1ns/1ns

bind input_capture_channels capture_props #(.NCH(NCH)) i_props (.clock(clock), .nrst(nrst),
  .regReq(regReq), .regRdata(regRdata), .capturePin(capturePin), .timebaseA(timebaseA),
  .timebaseB(timebaseB), .cpuIdle(cpuIdle), .cpuSleep(cpuSleep), .irqFlag(irqFlag),
  .wakeReq(wakeReq));

module input_capture_channels_bench;
  import capture_pkg::*;

  logic              clock = 1'b0;
  logic              nrst = 1'b0;
  regReq_s           regReq = '0;
  logic [DATA_W-1:0] regRdata, timebaseA = '0, timebaseB = '0;
  logic [NUM_CH-1:0] level = '0, capturePin, irqFlag, expFlag = '0;
  logic [1:0]        lag = 2'h0;
  logic              cpuIdle = 1'b0, cpuSleep = 1'b0, wakeReq;
  int                n_errors = 0, num_checks = 0;
  ctrl_s             cfg [NUM_CH];
  logic [DATA_W-1:0] expQ [NUM_CH][$];
  int                presc [NUM_CH], cnt [NUM_CH];
  logic              ov [NUM_CH], lock [NUM_CH], known [NUM_CH];

  input_capture_channels i_dut (.clock(clock), .nrst(nrst), .regReq(regReq),
    .regRdata(regRdata), .capturePin(capturePin), .timebaseA(timebaseA),
    .timebaseB(timebaseB), .cpuIdle(cpuIdle), .cpuSleep(cpuSleep), .irqFlag(irqFlag),
    .wakeReq(wakeReq));
  pin_source #(.NCH(NUM_CH)) i_src (.clock(clock), .nrst(nrst), .level(level), .lag(lag),
    .pin(capturePin));

  initial begin
    forever #2 clock = ~clock;
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clock);
    regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    regReq.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clock);
    regReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    regReq.rd <= 1'b0;
    #1 d = regRdata;
  endtask : rd

  // ***************************************************************
  // Reference model
  // ***************************************************************
  function automatic logic [15:0] conWord(ctrl_s c, logic o, logic b);
    return {2'h0, c.idleHalt, 5'h00, c.tbSel, c.perIrq, o, b, c.mode};
  endfunction : conWord

  // Passing through mode off first clears the prescaler and the event counter.
  task automatic setup(input int ch, input ctrl_s c);
    wr(CON_OFS[ch], 16'h0000);
    wr(CON_OFS[ch], conWord(c, 1'b0, 1'b0));
    wr(IRQ_FLAG_OFS, 16'h0000);
    expFlag = '0;
    cfg[ch] = c;
    presc[ch] = 0;
    cnt[ch] = 0;
    ov[ch] = 1'b0;
    known[ch] = 1'b1;
  endtask : setup

  task automatic pulse(input int ch, input logic rise);
    logic [15:0] vA;
    logic [15:0] vB;
    logic        qual;
    logic        run;
    vA = 16'($urandom);
    vB = 16'($urandom);
    run = !cpuSleep && !(cpuIdle && cfg[ch].idleHalt);
    @(posedge clock);
    timebaseA <= vA;
    timebaseB <= vB;
    lag <= 2'($urandom % 3);
    level[ch] <= rise;
    case (cfg[ch].mode)
      MODE_BOTH: qual = 1'b1;
      MODE_FALL: qual = !rise;
      MODE_RISE: qual = rise;
      MODE_RISE4, MODE_RISE16: begin
        if (rise && run) presc[ch]++;
        qual = rise && presc[ch] % (cfg[ch].mode == MODE_RISE4 ? 4 : 16) == 0;
      end
      default: qual = 1'b0;
    endcase
    if (cfg[ch].mode == MODE_WAKE && rise) expFlag[ch] = 1'b1;
    if (qual && run) begin
      if (lock[ch] || expQ[ch].size() == FIFO_DEPTH) begin
        known[ch] = 1'b0;
        if (cfg[ch].mode != MODE_BOTH) begin
          ov[ch] = 1'b1;
          lock[ch] = 1'b1;
        end
      end else begin
        expQ[ch].push_back(cfg[ch].tbSel ? vA : vB);
        cnt[ch]++;
        if (cfg[ch].mode == MODE_BOTH || cnt[ch] == cfg[ch].perIrq + 1) begin
          expFlag[ch] = 1'b1;
          cnt[ch] = 0;
        end
      end
    end
    repeat (10) @(posedge clock);
    #1 if (known[ch]) check(16'(irqFlag[ch]), 16'(expFlag[ch]), "flag");
  endtask : pulse

  task automatic edges(input int ch, input int n);
    repeat (n) begin
      pulse(ch, 1'b1);
      pulse(ch, 1'b0);
    end
  endtask : edges

  // Reads stop at the last stored entry; an empty buffer returns nothing useful.
  task automatic drain(input int ch);
    logic [15:0] d;
    rd(CON_OFS[ch], d);
    check(d, conWord(cfg[ch], ov[ch], expQ[ch].size() != 0), "control");
    while (expQ[ch].size() != 0) begin
      rd(BUF_OFS[ch], d);
      check(d, expQ[ch].pop_front(), "buffer");
    end
    lock[ch] = 1'b0;
    rd(CON_OFS[ch], d);
    check(d, conWord(cfg[ch], ov[ch], 1'b0), "emptied");
  endtask : drain

  initial begin
    repeat (100000) @(posedge clock);
    n_errors++;
    give_verdict();
  end

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial begin
    logic [15:0] d;
    ctrl_s       c;
    int          ch;
    logic [2:0]  modes [4];
    modes = '{MODE_FALL, MODE_RISE4, MODE_RISE16, MODE_BOTH};
    ch = $urandom(14108);
    foreach (lock[i]) lock[i] = 1'b0;
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    for (int i = 0; i < NUM_CH; i++) begin
      rd(CON_OFS[i], d);
      check(d, 16'h0000, "reset control");
    end
    wr(16'h0148, 16'hFFFF);
    rd(16'h0148, d);
    check(d, 16'h0000, "unmapped");
    wr(IRQ_EN_OFS, 16'h000F);
    for (int i = 0; i < NUM_CH; i++) begin
      c = '{idleHalt: 1'b0, tbSel: 1'($urandom), perIrq: 2'($urandom), mode: MODE_RISE};
      setup(i, c);
      edges(i, 6);
      drain(i);
      edges(i, 1);
      drain(i);
    end
    foreach (modes[k]) begin
      ch = $urandom % NUM_CH;
      c = '{idleHalt: 1'b0, tbSel: 1'($urandom), perIrq: 2'h3, mode: modes[k]};
      setup(ch, c);
      edges(ch, 16);
      drain(ch);
    end
    c = '{idleHalt: 1'b0, tbSel: 1'b0, perIrq: 2'h0, mode: MODE_RISE4};
    setup(1, c);
    edges(1, 2);
    setup(1, c);
    edges(1, 4);
    drain(1);
    @(posedge clock);
    cpuIdle <= 1'b1;
    c = '{idleHalt: 1'b1, tbSel: 1'b1, perIrq: 2'h0, mode: MODE_RISE};
    setup(2, c);
    edges(2, 1);
    c.idleHalt = 1'b0;
    setup(2, c);
    edges(2, 1);
    drain(2);
    @(posedge clock);
    cpuIdle <= 1'b0;
    cpuSleep <= 1'b1;
    c = '{idleHalt: 1'b0, tbSel: 1'b0, perIrq: 2'h3, mode: MODE_WAKE};
    setup(3, c);
    edges(3, 1);
    check(16'(wakeReq), 16'h0001, "wake");
    drain(3);
    wr(IRQ_EN_OFS, 16'h0000);
    repeat (2) @(posedge clock);
    #1 check(16'(wakeReq), 16'h0000, "masked wake");
    c.mode = MODE_RISE;
    setup(3, c);
    edges(3, 1);
    drain(3);
    give_verdict();
  end
endmodule : input_capture_channels_bench
